// [rms_pkg.sv]
// rms_pkg: constants and types for the radio mode sequencer
// assumes a 200 MHz system clock; no bus, all configuration on ports
package rms_pkg;

  // chip operating modes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h5;

  // launch transition field codes
  localparam logic [1:0] LAUNCH_LOWPOWER = 2'h0;
  localparam logic [1:0] LAUNCH_RX = 2'h1;
  localparam logic [1:0] LAUNCH_TX = 2'h2;
  localparam logic [1:0] LAUNCH_TX_ON_FIFO = 2'h3;

  // timer step codes
  localparam logic [1:0] STEP_OFF = 2'h0;
  localparam logic [1:0] STEP_64US = 2'h1;
  localparam logic [1:0] STEP_4MS = 2'h2;
  localparam logic [1:0] STEP_262MS = 2'h3;

  // timer base tick
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_US = 64;
  localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);
  // 4.1 ms and 262 ms are 64 and 4095 base ticks
  localparam logic [11:0] STEP_4MS_TICKS = 12'h040;
  localparam logic [11:0] STEP_262MS_TICKS = 12'hfff;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_TX,
    ST_RX,
    ST_PKT_HELD,
    ST_LOWPOWER,
    ST_RX_TIMEOUT,
    ST_WAIT_FIFO
  } rms_state_t;

endpackage : rms_pkg

// [rms_timer_if.sv]
// rms_timer_if: sequencer to timer pair control and events
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface rms_timer_if;
  logic restart;
  logic [1:0] first_timer_step;
  logic [1:0] second_timer_step;
  logic [7:0] first_timer_multiplier;
  logic [7:0] second_timer_multiplier;
  logic first_timer_event;
  logic second_timer_event;
  modport seq (output restart, first_timer_step, second_timer_step,
    first_timer_multiplier, second_timer_multiplier,
    input first_timer_event, second_timer_event);
  modport tmr (input restart, first_timer_step, second_timer_step,
    first_timer_multiplier, second_timer_multiplier,
    output first_timer_event, second_timer_event);
endinterface : rms_timer_if
`default_nettype wire

// [rms_timers.sv]
// rms_timers: alternating first/second interval timers
// assumes restart pulses on sequencer launch and on stop
`timescale 1ns/10ps
`default_nettype none
module rms_timers (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // sequencer side
  rms_timer_if.tmr tif
);
  import rms_pkg::*;

  logic [13:0] pre_cnt;
  logic [11:0] step_cnt;
  logic [7:0] mult_cnt;
  logic phase_second;
  logic running;
  logic [1:0] cur_step;
  logic [7:0] cur_mult;
  logic [11:0] step_ticks;
  logic base_tick;
  logic step_done;
  logic interval_done;

  assign cur_step = phase_second ? tif.second_timer_step
                                 : tif.first_timer_step;
  assign cur_mult = phase_second ? tif.second_timer_multiplier
                                 : tif.first_timer_multiplier;
  assign step_ticks = (cur_step == STEP_262MS) ? STEP_262MS_TICKS :
                      (cur_step == STEP_4MS) ? STEP_4MS_TICKS : 12'h001;
  assign base_tick = (pre_cnt == TICK_LAST);
  assign step_done = base_tick && (step_cnt + 12'h001 >= step_ticks);
  // a zero multiplier is taken as one step, never a stuck interval
  assign interval_done = running && (cur_step != STEP_OFF) && step_done
                      && (mult_cnt + 8'h01 >= cur_mult);

  // sequence runs regardless of sequencer state; off step stalls it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || tif.restart) begin
      pre_cnt <= 14'h0000;
      step_cnt <= 12'h000;
      mult_cnt <= 8'h00;
      phase_second <= 1'b0;
      running <= tif.restart;
      tif.first_timer_event <= 1'b0;
      tif.second_timer_event <= 1'b0;
    end else begin
      tif.first_timer_event <= interval_done && !phase_second;
      tif.second_timer_event <= interval_done && phase_second;
      if (!running || cur_step == STEP_OFF) begin
        pre_cnt <= 14'h0000;
      end else if (interval_done) begin
        pre_cnt <= 14'h0000;
        step_cnt <= 12'h000;
        mult_cnt <= 8'h00;
        phase_second <= !phase_second;
      end else begin
        pre_cnt <= base_tick ? 14'h0000 : pre_cnt + 14'h0001;
        if (step_done) begin
          step_cnt <= 12'h000;
          mult_cnt <= mult_cnt + 8'h01;
        end else if (base_tick) begin
          step_cnt <= step_cnt + 12'h001;
        end
      end
    end
  end

  chk_timer_alternate: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !(tif.first_timer_event && tif.second_timer_event))
    else $error("both timer events at once");

endmodule : rms_timers
`default_nettype wire

// [rms_sequencer.sv]
// rms_sequencer: autonomous mode sequencer with collision restart
// assumes interrupt inputs are one-cycle pulses on sys_clk
// Function
// - collision detector armed only while collision_restart_enable is 1.
// - in receive, sudden signal rise above threshold restarts receiver.
// - collision threshold counts in 1 dB steps.
// - sequencer acts only with frequency/on-off keying modem selected.
// - launch bit in sleep or standby starts sequencer from off.
// - stop bit forces off state from any state.
// - low-power mode at launch is latched as initial mode.
// - off entered from low-power selection returns chip to initial mode.
// - idle keeps low-power mode and waits only for first timer.
// - idle_lowpower_select 0 is standby, 1 is sleep.
// - transmit state enables transmitter, receive state the receiver.
// - packet-held state keeps receiver on, packet in FIFO.
// - any of three receive timeouts is a receive-timeout event.
// - launch field picks low-power, receive, transmit, or transmit on FIFO.
// - low-power choice 0 goes off, 1 goes idle.
// - first timer in idle goes to transmit (0) or receive (1).
// - timers alternate, each interval step times multiplier.
`timescale 1ns/10ps
`default_nettype none
module rms_sequencer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic fsk_family_sel,
  input wire logic seq_launch_bit,
  input wire logic seq_stop_bit,
  input wire logic idle_lowpower_select,
  input wire logic [1:0] launch_transition_field,
  input wire logic lowpower_choice,
  input wire logic idle_exit_select,
  input wire logic [1:0] first_timer_step,
  input wire logic [1:0] second_timer_step,
  input wire logic [7:0] first_timer_multiplier,
  input wire logic [7:0] second_timer_multiplier,
  input wire logic collision_restart_enable,
  input wire logic [7:0] collision_level_threshold,
  // chip mode and events
  input wire logic [2:0] chip_mode,
  input wire logic fifo_level_event,
  input wire logic signal_level_timeout,
  input wire logic preamble_wait_timeout,
  input wire logic sync_word_timeout,
  input wire logic [7:0] signal_level,
  // outputs
  output logic [2:0] seq_mode_request,
  output logic seq_mode_valid,
  output logic transmit_enable,
  output logic receive_enable,
  output logic receiver_restart,
  output logic rx_timeout_flag,
  output logic timer_event_one,
  output logic timer_event_two,
  output var rms_pkg::rms_state_t seq_state
);
  import rms_pkg::*;

  rms_timer_if tif();

  rms_state_t state;
  rms_state_t next_state;
  logic [2:0] initial_mode;
  logic [7:0] prev_level;
  logic level_valid;
  logic chip_lowpower;
  logic launch_ok;
  logic rx_timeout_evt;
  logic collision_armed;
  logic level_rise;
  logic [8:0] level_step;
  logic [2:0] next_mode;
  logic next_valid;

  ////////////////////////////////////////////////////////////////////////
  // timer pair
  assign tif.restart = (state == ST_OFF && launch_ok) || seq_stop_bit;
  assign tif.first_timer_step = first_timer_step;
  assign tif.second_timer_step = second_timer_step;
  assign tif.first_timer_multiplier = first_timer_multiplier;
  assign tif.second_timer_multiplier = second_timer_multiplier;

  rms_timers u_timers (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign chip_lowpower = (chip_mode == MODE_SLEEP)
                      || (chip_mode == MODE_STANDBY);
  assign launch_ok = seq_launch_bit && chip_lowpower && fsk_family_sel
                  && !seq_stop_bit;
  assign rx_timeout_evt = signal_level_timeout || preamble_wait_timeout
                       || sync_word_timeout;

  // threshold is in 1 dB units, matching the signal_level scale
  assign collision_armed = collision_restart_enable
                        && (state == ST_RX);
  assign level_step = {1'b0, signal_level} - {1'b0, prev_level};
  assign level_rise = collision_armed && level_valid && !level_step[8]
                   && (level_step[7:0] > collision_level_threshold);

  ////////////////////////////////////////////////////////////////////////
  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (launch_ok) begin
          case (launch_transition_field)
            LAUNCH_RX: next_state = ST_RX;
            LAUNCH_TX: next_state = ST_TX;
            LAUNCH_TX_ON_FIFO: next_state = ST_WAIT_FIFO;
            default: next_state = ST_LOWPOWER;
          endcase
        end
      end
      ST_LOWPOWER: begin
        next_state = lowpower_choice ? ST_IDLE : ST_OFF;
      end
      ST_IDLE: begin
        if (tif.first_timer_event) begin
          next_state = idle_exit_select ? ST_RX : ST_TX;
        end
      end
      ST_WAIT_FIFO: begin
        if (fifo_level_event) begin
          next_state = ST_TX;
        end
      end
      ST_RX: begin
        if (rx_timeout_evt) begin
          next_state = ST_RX_TIMEOUT;
        end
      end
      // transmit, packet-held and timeout hold; only the stop or modem override below leaves them
      ST_TX: next_state = ST_TX;
      ST_PKT_HELD: next_state = ST_PKT_HELD;
      ST_RX_TIMEOUT: next_state = ST_RX_TIMEOUT;
      default: next_state = ST_OFF;
    endcase
    // stop wins over anything, and a modem change halts the sequencer
    if (seq_stop_bit || !fsk_family_sel) begin
      next_state = ST_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode requests per state
  always_comb begin
    next_mode = chip_mode;
    next_valid = 1'b1;
    case (next_state)
      ST_IDLE: next_mode = idle_lowpower_select ? MODE_SLEEP
                                                : MODE_STANDBY;
      ST_TX: next_mode = MODE_TX;
      ST_RX: next_mode = MODE_RX;
      ST_PKT_HELD: next_mode = MODE_RX;
      ST_RX_TIMEOUT: next_mode = MODE_RX;
      ST_WAIT_FIFO: next_mode = initial_mode;
      ST_LOWPOWER: next_mode = initial_mode;
      ST_OFF: begin
        next_mode = initial_mode;
        next_valid = (state == ST_LOWPOWER);
      end
      default: next_valid = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_OFF;
      seq_state <= ST_OFF;
      initial_mode <= MODE_STANDBY;
      seq_mode_request <= MODE_STANDBY;
      seq_mode_valid <= 1'b0;
      transmit_enable <= 1'b0;
      receive_enable <= 1'b0;
    end else begin
      state <= next_state;
      seq_state <= next_state;
      if (state == ST_OFF && launch_ok) begin
        initial_mode <= chip_mode;
      end
      seq_mode_request <= next_mode;
      seq_mode_valid <= next_valid;
      transmit_enable <= (next_state == ST_TX);
      receive_enable <= (next_state == ST_RX)
                     || (next_state == ST_PKT_HELD)
                     || (next_state == ST_RX_TIMEOUT);
    end
  end

  // collision detector history and restart strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prev_level <= 8'h00;
      level_valid <= 1'b0;
      receiver_restart <= 1'b0;
    end else begin
      prev_level <= signal_level;
      level_valid <= collision_armed && !level_rise;
      receiver_restart <= level_rise;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_timeout_flag <= 1'b0;
      timer_event_one <= 1'b0;
      timer_event_two <= 1'b0;
    end else begin
      rx_timeout_flag <= (state == ST_RX) && rx_timeout_evt;
      timer_event_one <= tif.first_timer_event;
      timer_event_two <= tif.second_timer_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_stop_forces_off: assert property (@(posedge sys_clk)
    disable iff (sys_rst) seq_stop_bit |=> (state == ST_OFF))
    else $error("stop did not force off");

  chk_reset_off_hold: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && !launch_ok) |=> (state == ST_OFF))
    else $error("left off without launch");

  chk_launch_route: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && launch_ok && fsk_family_sel && !seq_stop_bit
     && launch_transition_field == LAUNCH_RX)
    |=> (state == ST_RX) ##0 receive_enable)
    else $error("launch to receive wrong");

  chk_lowpower_choice: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_LOWPOWER && !seq_stop_bit && fsk_family_sel)
    |=> (state == ($past(lowpower_choice) ? ST_IDLE : ST_OFF)))
    else $error("low-power selection wrong");

  chk_idle_waits: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_IDLE && !tif.first_timer_event && !seq_stop_bit
     && fsk_family_sel) |=> (state == ST_IDLE))
    else $error("idle left without timer");

  chk_idle_exit: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_IDLE && tif.first_timer_event && !seq_stop_bit
     && fsk_family_sel && idle_exit_select) |=> (state == ST_RX))
    else $error("idle exit wrong");

  chk_idle_mode: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_IDLE) |-> (seq_mode_request ==
      (idle_lowpower_select ? MODE_SLEEP : MODE_STANDBY)) || $changed(state)
      || $changed(idle_lowpower_select))
    else $error("idle mode wrong");

  chk_initial_return: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_LOWPOWER && !lowpower_choice)
    |=> seq_mode_valid && (seq_mode_request == initial_mode))
    else $error("initial mode not restored");

  chk_collision_armed: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !collision_restart_enable |=> !receiver_restart)
    else $error("restart while disarmed");

  chk_modem_gate: assert property (@(posedge sys_clk)
    disable iff (sys_rst) !fsk_family_sel |=> (state == ST_OFF))
    else $error("ran with wrong modem");

  chk_launch_lowpower: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && launch_ok
     && launch_transition_field == LAUNCH_LOWPOWER)
    |=> (state == ST_LOWPOWER))
    else $error("launch to low power wrong");

  chk_launch_tx: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && launch_ok && launch_transition_field == LAUNCH_TX)
    |=> (state == ST_TX) ##0 transmit_enable)
    else $error("launch to transmit wrong");

  chk_fifo_wait: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_WAIT_FIFO && fifo_level_event && !seq_stop_bit
     && fsk_family_sel) |=> (state == ST_TX))
    else $error("fifo event did not start transmit");

  chk_launch_refused: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && !chip_lowpower) |=> (state == ST_OFF))
    else $error("launched outside low power");

  chk_launch_latch: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_OFF && launch_ok) |=> (initial_mode == $past(chip_mode)))
    else $error("initial mode not latched");

  chk_tx_enable: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_TX) |-> (transmit_enable && !receive_enable))
    else $error("transmit state enables wrong");

  chk_rx_enable: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_RX || state == ST_PKT_HELD)
    |-> (receive_enable && !transmit_enable))
    else $error("receive state enables wrong");

  chk_idle_quiet: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_IDLE) |-> (!transmit_enable && !receive_enable))
    else $error("radio enabled in idle");

  chk_timeout_enter: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    (state == ST_RX && rx_timeout_evt && !seq_stop_bit && fsk_family_sel)
    |=> (state == ST_RX_TIMEOUT) ##0 rx_timeout_flag)
    else $error("receive timeout not taken");

  chk_restart_only_rx: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    receiver_restart |-> ($past(state) == ST_RX))
    else $error("restart outside receive");

  chk_restart_pulse: assert property (@(posedge sys_clk)
    disable iff (sys_rst) receiver_restart |=> !receiver_restart)
    else $error("restart longer than one cycle");

  chk_timer_mirror: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    timer_event_two == $past(tif.second_timer_event))
    else $error("second timer event not forwarded");

endmodule : rms_sequencer
`default_nettype wire

// [rms_sequencer_bench.sv]
// rms_sequencer_bench: self-checking bench for the mode sequencer
// assumes rms_pkg and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
module rms_sequencer_bench;
  import rms_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fsk_family_sel = 1'b1;
  logic seq_launch_bit = 1'b0;
  logic seq_stop_bit = 1'b0;
  logic idle_lowpower_select = 1'b0;
  logic [1:0] launch_transition_field = 2'h0;
  logic lowpower_choice = 1'b0;
  logic idle_exit_select = 1'b0;
  logic collision_restart_enable = 1'b0;
  logic [7:0] collision_level_threshold = 8'h0a;
  logic [2:0] chip_mode = 3'h1;
  logic fifo_level_event = 1'b0;
  logic [2:0] tmo = 3'h0;
  logic [7:0] signal_level = 8'h00;
  logic [2:0] seq_mode_request;
  logic seq_mode_valid, transmit_enable, receive_enable;
  logic receiver_restart, rx_timeout_flag, timer_event_one, timer_event_two;
  rms_state_t seq_state;
  int errors = 0;
  int checks = 0;
  bit seen;
  int n;

  always #2.5 sys_clk = ~sys_clk;

  rms_sequencer rms_sequencer_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .fsk_family_sel(fsk_family_sel),
    .seq_launch_bit(seq_launch_bit), .seq_stop_bit(seq_stop_bit),
    .idle_lowpower_select(idle_lowpower_select),
    .launch_transition_field(launch_transition_field),
    .lowpower_choice(lowpower_choice), .idle_exit_select(idle_exit_select),
    .first_timer_step(STEP_64US), .second_timer_step(STEP_64US),
    .first_timer_multiplier(8'h01), .second_timer_multiplier(8'h02),
    .collision_restart_enable(collision_restart_enable),
    .collision_level_threshold(collision_level_threshold),
    .chip_mode(chip_mode), .fifo_level_event(fifo_level_event),
    .signal_level_timeout(tmo[0]), .preamble_wait_timeout(tmo[1]),
    .sync_word_timeout(tmo[2]), .signal_level(signal_level),
    .seq_mode_request(seq_mode_request), .seq_mode_valid(seq_mode_valid),
    .transmit_enable(transmit_enable), .receive_enable(receive_enable),
    .receiver_restart(receiver_restart), .rx_timeout_flag(rx_timeout_flag),
    .timer_event_one(timer_event_one), .timer_event_two(timer_event_two),
    .seq_state(seq_state)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check_bit(input string what, input logic exp, logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_mode(input string what, input logic [2:0] exp,
                            input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_mode

  task automatic check_state(input string what, input rms_state_t exp);
    checks++;
    if (seq_state !== exp) begin
      errors++;
      $display("wrong value %s expected %s seen %s", what, exp.name(),
               seq_state.name());
    end
  endtask : check_state

  // a transition may take one or two edges; poll a few cycles only
  task automatic wait_state(input string what, input rms_state_t exp);
    for (int i = 0; i < 4 && seq_state !== exp; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check_state(what, exp);
    if (seq_state !== exp) final_report();
  endtask : wait_state

  task automatic launch(input logic [1:0] fld, input logic [2:0] mode);
    @(posedge sys_clk);
    launch_transition_field <= fld;
    chip_mode <= mode;
    seq_launch_bit <= 1'b1;
    @(posedge sys_clk);
    seq_launch_bit <= 1'b0;
    #1;
  endtask : launch

  task automatic stop();
    @(posedge sys_clk);
    seq_stop_bit <= 1'b1;
    @(posedge sys_clk);
    seq_stop_bit <= 1'b0;
    #1;
    wait_state("state after stop", ST_OFF);
  endtask : stop

  // settle on the first level, then step to the second and watch
  task automatic level_step(input logic [7:0] a, input logic [7:0] b);
    @(posedge sys_clk);
    signal_level <= a;
    // the jump onto a may restart once; let that pulse pass first
    repeat (3) @(posedge sys_clk);
    signal_level <= b;
    seen = 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (receiver_restart === 1'b1) seen = 1'b1;
    end
  endtask : level_step

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check_state("state after reset", ST_OFF);
    check_bit("transmit after reset", 1'b0, transmit_enable);
    check_mode("mode after reset", MODE_STANDBY, seq_mode_request);
    $display("test reset done");

    launch(LAUNCH_RX, MODE_RX);
    wait_state("launch outside low power", ST_OFF);
    fsk_family_sel <= 1'b0;
    launch(LAUNCH_RX, MODE_STANDBY);
    wait_state("launch without fsk", ST_OFF);
    fsk_family_sel <= 1'b1;
    launch(LAUNCH_RX, MODE_STANDBY);
    wait_state("launch to receive", ST_RX);
    fsk_family_sel <= 1'b0;
    #5;
    wait_state("fsk dropped in receive", ST_OFF);
    fsk_family_sel <= 1'b1;
    $display("test refusal done");

    launch(LAUNCH_RX, MODE_SLEEP);
    wait_state("receive state", ST_RX);
    check_bit("receiver on", 1'b1, receive_enable);
    stop();
    launch(LAUNCH_TX, MODE_STANDBY);
    wait_state("transmit state", ST_TX);
    check_bit("transmitter on", 1'b1, transmit_enable);
    stop();
    check_bit("transmitter off", 1'b0, transmit_enable);
    launch(LAUNCH_TX_ON_FIFO, MODE_STANDBY);
    wait_state("waiting for fifo", ST_WAIT_FIFO);
    @(posedge sys_clk);
    fifo_level_event <= 1'b1;
    @(posedge sys_clk);
    fifo_level_event <= 1'b0;
    #1;
    wait_state("transmit on fifo", ST_TX);
    stop();
    lowpower_choice <= 1'b0;
    launch(LAUNCH_LOWPOWER, MODE_SLEEP);
    chip_mode <= MODE_STANDBY;
    wait_state("low power to off", ST_OFF);
    check_bit("initial mode valid", 1'b1, seq_mode_valid);
    check_mode("initial mode", MODE_SLEEP, seq_mode_request);
    $display("test launch field done");

    for (int k = 0; k < 2; k++) begin
      idle_lowpower_select <= k[0];
      idle_exit_select <= k[0];
      lowpower_choice <= 1'b1;
      launch(LAUNCH_LOWPOWER, MODE_STANDBY);
      n = 1;
      wait_state("idle state", ST_IDLE);
      check_mode("idle mode", k[0] ? MODE_SLEEP : MODE_STANDBY,
                 seq_mode_request);
      check_bit("transmitter off in idle", 1'b0, transmit_enable);
      @(posedge sys_clk);
      fifo_level_event <= 1'b1;
      @(posedge sys_clk);
      fifo_level_event <= 1'b0;
      #1;
      wait_state("idle ignores fifo", ST_IDLE);
      while (timer_event_one !== 1'b1 && n < 14000) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      // one 64 us step is 12800 cycles; allow a few cycles of pipeline
      check_bit("first timer interval", 1'b1,
                n >= 12790 && n <= 12810);
      if (n >= 14000) final_report();
      wait_state("idle exit", k[0] ? ST_RX : ST_TX);
      if (k == 0) begin
        n = 0;
        while (timer_event_two !== 1'b1 && n < 26000) begin
          @(posedge sys_clk);
          #1;
          n++;
        end
        // one 12800-cycle step times multiplier 2 after the first event
        check_bit("second timer interval", 1'b1, n == 25600);
        if (n >= 26000) final_report();
      end
      stop();
    end
    $display("test idle and timer done");

    launch(LAUNCH_LOWPOWER, MODE_STANDBY);
    wait_state("idle before stop", ST_IDLE);
    stop();
    $display("test stop in idle done");

    collision_restart_enable <= 1'b1;
    launch(LAUNCH_RX, MODE_STANDBY);
    wait_state("receive for collision", ST_RX);
    level_step(8'h14, 8'h1f);
    check_bit("restart on rise of 11", 1'b1, seen);
    level_step(8'h28, 8'h32);
    check_bit("no restart on rise of 10", 1'b0, seen);
    collision_restart_enable <= 1'b0;
    level_step(8'h3c, 8'h5a);
    check_bit("no restart when disarmed", 1'b0, seen);
    stop();
    $display("test collision done");

    for (int k = 0; k < 3; k++) begin
      launch(LAUNCH_RX, MODE_STANDBY);
      wait_state("receive for timeout", ST_RX);
      @(posedge sys_clk);
      tmo <= 3'h1 << k;
      @(posedge sys_clk);
      tmo <= 3'h0;
      #1;
      // flag stands only for the cycle after the event edge
      check_bit("timeout flag", 1'b1, rx_timeout_flag);
      @(posedge sys_clk);
      #1;
      check_bit("timeout flag pulse", 1'b0, rx_timeout_flag);
      check_state("timeout state", ST_RX_TIMEOUT);
      stop();
    end
    $display("test receive timeout done");
    final_report();
  end
endmodule : rms_sequencer_bench
`default_nettype wire
